// file: fidsc_core.sv
// Serial command engine for identification reads, parameter table and security erase
// What this block does
// - 90h, zero address, single-bit ID pair out
// - 92h, 16 address clocks one bit each on io0, dual out
// - 94h, 12 address clocks one bit each on io0, quad output
// - Dual/quad IDs alternate until deselect
// - 4Bh, 32 dummy clocks, 64-bit ID
// - Unique ID fixed, no command alters it
// - 9Fh returns maker, type, capacity bytes
// - 5Ah, address, dummies, data from 40th
// - 256-byte table, low address byte starts
// - Erase 44h refused without write enable
// - Erase address fields select register 1-3
// - Erase only on deselect after exactly 32 clocks
// - Self-timed erase, busy flag during it
// - Erase completion clears write enable latch
// - Locked security register ignores erase
`default_nettype none
module fidsc_core
  import fidsc_pkg::*;
#(
  parameter logic [7:0] MFR_ID = 8'h5c,      // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h17,   // Arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40,    // Arbitrary value
  parameter logic [7:0] CAPACITY = 8'h18,    // Arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // Arbitrary value
  parameter int ERASE_CYCLES = SECURITY_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic [3:0] spi_io_in,
  output logic [3:0] spi_io_out,
  output logic [3:0] spi_io_oe,
  input wire logic write_enable_latch,
  input wire logic [2:0] security_lock_bits,
  output logic [7:0] param_table_addr,
  input wire logic [7:0] param_table_data,
  output logic busy,
  output logic erase_start,
  output logic [1:0] erase_select,
  output logic latch_clear
);
  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  fidsc_pins_type pins;
  logic cs_prev;
  logic sclk_prev;

  // Serial clock must stay well below a quarter of clk; output lags the falling edge by about three cycles
  fidsc_sync #(.W(6), .RESET_VAL(6'h20)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({spi_cs_n, spi_sclk, spi_io_in}),
    .q(pins)
  );

  wire sclk_rise = pins.sclk && !sclk_prev && !pins.cs_n;
  wire sclk_fall = !pins.sclk && sclk_prev && !pins.cs_n;
  wire cs_rise = pins.cs_n && !cs_prev;
  wire rx_bit = pins.io[0];

  // ****************************************
  // Frame state
  // ****************************************
  fidsc_state_type state;
  fidsc_state_type next_state;
  logic [CNT_W-1:0] count;
  logic [7:0] opcode;
  logic [23:0] addr;
  logic [2:0] lanes;
  logic [CNT_W-1:0] pre_len;
  logic [2:0] bpos;
  logic [2:0] byte_idx;
  logic [7:0] ptr;

  wire [CNT_W-1:0] count_inc = (count == CNT_MAX) ? count : count + 1'b1;
  wire [7:0] full_op = {opcode[6:0], rx_bit};
  wire cmd_done = (state == ST_CMD) && sclk_rise && (count == OPCODE_LAST);

  // ****************************************
  // Opcode decode
  // ****************************************
  wire op_single = (full_op == OP_ID_SINGLE);
  wire op_dual = (full_op == OP_ID_DUAL);
  wire op_quad = (full_op == OP_ID_QUAD);
  wire op_uid = (full_op == OP_UNIQUE_ID);
  wire op_std = (full_op == OP_STD_ID);
  wire op_table = (full_op == OP_PARAM_TABLE);
  wire op_erase = (full_op == OP_SEC_ERASE);
  wire op_read = op_single || op_dual || op_quad || op_uid || op_std || op_table;

  wire [2:0] dec_lanes = op_dual ? LANES_DUAL : (op_quad ? LANES_QUAD : LANES_SINGLE);
  wire [CNT_W-1:0] dec_pre = op_single ? PRE_ID_SINGLE :
                             op_dual ? PRE_ID_DUAL :
                             op_quad ? PRE_ID_QUAD :
                             op_uid ? PRE_UNIQUE_ID :
                             op_table ? PRE_PARAM_TABLE : PRE_STD_ID;

  wire pre_done = (state == ST_PRE) && sclk_rise && (opcode != OP_SEC_ERASE)
                  && (count_inc == OPCODE_CLOCKS + pre_len);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (!pins.cs_n) begin
          next_state = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmd_done) begin
          if (op_read && dec_pre == PRE_STD_ID) begin
            next_state = ST_DATA;
          end else if (op_read || op_erase) begin
            next_state = ST_PRE;
          end else begin
            next_state = ST_SKIP;
          end
        end
      end
      ST_PRE: begin
        if (pre_done) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        next_state = ST_DATA;
      end
      ST_SKIP: begin
        next_state = ST_SKIP;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (pins.cs_n) begin
      next_state = ST_IDLE;
    end
  end

  // ****************************************
  // Output byte selection
  // ****************************************
  wire [7:0] pair_byte = byte_idx[0] ? DEVICE_ID : MFR_ID;
  wire [7:0] std_byte = (byte_idx == 3'h0) ? MFR_ID : ((byte_idx == 3'h1) ? MEM_TYPE : CAPACITY);
  wire [7:0] uid_byte = UNIQUE_ID[8 * (7 - int'(byte_idx)) +: 8];
  wire [7:0] cur_byte = (opcode == OP_UNIQUE_ID) ? uid_byte :
                        (opcode == OP_STD_ID) ? std_byte :
                        (opcode == OP_PARAM_TABLE) ? param_table_data : pair_byte;
  wire [7:0] shifted = cur_byte << (BIT_FIRST - bpos);
  wire [3:0] tx_bits = (lanes == LANES_QUAD) ? shifted[7:4] :
                       (lanes == LANES_DUAL) ? {2'h0, shifted[7:6]} : {2'h0, shifted[7], 1'b0};
  wire [3:0] tx_oe = (lanes == LANES_QUAD) ? OE_QUAD : ((lanes == LANES_DUAL) ? OE_DUAL : OE_SINGLE);
  wire byte_end = (bpos < lanes);
  wire [2:0] next_idx = ((opcode == OP_STD_ID) && (byte_idx == STD_ID_LAST)) ? 3'h0 : byte_idx + 1'b1;

  // ****************************************
  // Erase acceptance
  // ****************************************
  wire [3:0] sec_sel = addr[SEC_SEL_MSB:SEC_SEL_LSB];
  wire sel_ok = (sec_sel >= SEC_SEL_FIRST) && (sec_sel <= SEC_SEL_LAST);
  wire [1:0] sel_idx = 2'(sec_sel - SEC_SEL_FIRST);
  wire fields_ok = (addr[SEC_HIGH_MSB:SEC_HIGH_LSB] == SEC_HIGH_VALUE)
                   && (addr[SEC_MID_MSB:SEC_MID_LSB] == SEC_MID_VALUE) && sel_ok;
  wire erase_ok = cs_rise && (state == ST_PRE) && (opcode == OP_SEC_ERASE)
                  && (count == ERASE_FRAME_CLOCKS)
                  && write_enable_latch
                  && fields_ok && !security_lock_bits[sel_idx]
                  && !busy;

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cs_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      state <= next_state;
      cs_prev <= pins.cs_n;
      sclk_prev <= pins.sclk;
    end
  end

  // Input side: everything sampled on rising serial clock edges
  always_ff @(posedge clk) begin
    if (rst || pins.cs_n) begin
      count <= '0;
      opcode <= 8'h00;
      addr <= 24'h00_0000;
    end else if (sclk_rise) begin
      count <= count_inc;
      if (state == ST_CMD) begin
        opcode <= full_op;
      end
      if (state == ST_PRE && count <= ADDR_LAST) begin
        addr <= {addr[22:0], rx_bit};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lanes <= LANES_SINGLE;
      pre_len <= '0;
    end else if (cmd_done) begin
      lanes <= dec_lanes;
      pre_len <= dec_pre;
    end
  end

  // Output side: next bits launched on falling serial clock edges
  always_ff @(posedge clk) begin
    if (rst || pins.cs_n) begin
      spi_io_out <= 4'h0;
      spi_io_oe <= 4'h0;
      bpos <= BIT_FIRST;
      byte_idx <= 3'h0;
    end else if (state == ST_DATA && sclk_fall) begin
      spi_io_out <= tx_bits;
      spi_io_oe <= tx_oe;
      bpos <= bpos - lanes;
      if (byte_end) begin
        byte_idx <= next_idx;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr <= 8'h00;
    end else if (sclk_rise && state == ST_PRE && count == ADDR_LAST && opcode == OP_PARAM_TABLE) begin
      ptr <= {addr[6:0], rx_bit};
    end else if (state == ST_DATA && sclk_fall && byte_end && opcode == OP_PARAM_TABLE) begin
      ptr <= ptr + 1'b1;
    end
  end

  assign param_table_addr = ptr;

  always_ff @(posedge clk) begin
    if (rst) begin
      erase_start <= 1'b0;
      erase_select <= 2'h0;
    end else begin
      erase_start <= erase_ok;
      if (erase_ok) begin
        erase_select <= sel_idx;
      end
    end
  end

  fidsc_erase #(.ERASE_CYCLES(ERASE_CYCLES)) u_erase (
    .clk(clk),
    .rst(rst),
    .start(erase_start),
    .busy(busy),
    .done(latch_clear)
  );
endmodule
`default_nettype wire

// file: fidsc_pkg.sv
// Shared constants and types for the identification and security-erase command block
`default_nettype none
package fidsc_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_ID_SINGLE = 8'h90;
  localparam logic [7:0] OP_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  localparam logic [7:0] OP_UNIQUE_ID = 8'h4b;
  localparam logic [7:0] OP_STD_ID = 8'h9f;
  localparam logic [7:0] OP_PARAM_TABLE = 8'h5a;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;

  // ****************************************
  // Frame lengths in serial clocks
  // ****************************************
  localparam int CNT_W = 7;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [6:0] OPCODE_LAST = 7'h07;
  localparam logic [6:0] OPCODE_CLOCKS = 7'h08;
  localparam logic [6:0] ADDR_LAST = 7'h1f;
  localparam logic [6:0] ERASE_FRAME_CLOCKS = 7'h20;
  localparam logic [6:0] PRE_ID_SINGLE = 7'h18;
  localparam logic [6:0] PRE_ID_DUAL = 7'h10;
  localparam logic [6:0] PRE_ID_QUAD = 7'h0c;
  localparam logic [6:0] PRE_UNIQUE_ID = 7'h20;
  localparam logic [6:0] PRE_STD_ID = 7'h00;
  localparam logic [6:0] PRE_PARAM_TABLE = 7'h20;
  localparam logic [2:0] STD_ID_LAST = 3'h2;

  // ****************************************
  // Lanes and output enables
  // ****************************************
  localparam logic [2:0] LANES_SINGLE = 3'h1;
  localparam logic [2:0] LANES_DUAL = 3'h2;
  localparam logic [2:0] LANES_QUAD = 3'h4;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [2:0] BIT_FIRST = 3'h7;

  // ****************************************
  // Security register address fields
  // ****************************************
  localparam int SEC_HIGH_MSB = 23;
  localparam int SEC_HIGH_LSB = 16;
  localparam int SEC_SEL_MSB = 15;
  localparam int SEC_SEL_LSB = 12;
  localparam int SEC_MID_MSB = 11;
  localparam int SEC_MID_LSB = 8;
  localparam logic [7:0] SEC_HIGH_VALUE = 8'h00;
  localparam logic [3:0] SEC_MID_VALUE = 4'h0;
  localparam logic [3:0] SEC_SEL_FIRST = 4'h1;
  localparam logic [3:0] SEC_SEL_LAST = 4'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 40;
  localparam int SECURITY_ERASE_TIME_US = 100;
  localparam int SECURITY_ERASE_CYCLES = SECURITY_ERASE_TIME_US * CLK_MHZ;
  localparam int ERASE_CNT_W = 24;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } fidsc_pins_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_PRE = 5'h04,
    ST_DATA = 5'h08,
    ST_SKIP = 5'h10
  } fidsc_state_type;
endpackage
`default_nettype wire

// file: fidsc_sync.sv
// Two-stage synchroniser for the serial pins
`default_nettype none
module fidsc_sync
  import fidsc_pkg::*;
#(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// file: fidsc_erase.sv
// Self-timed security register erase sequencer
`default_nettype none
module fidsc_erase
  import fidsc_pkg::*;
#(
  parameter int ERASE_CYCLES = SECURITY_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [ERASE_CNT_W-1:0] remain;
  localparam logic [ERASE_CNT_W-1:0] LOAD = ERASE_CNT_W'(ERASE_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      remain <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        remain <= LOAD;
      end else if (busy) begin
        if (remain == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: fidsc_monitor.sv
// Checker for erase handshake and serial output timing
`default_nettype none
module fidsc_monitor
  import fidsc_pkg::*;
#(
  parameter int ERASE_CYCLES = SECURITY_ERASE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic [3:0] spi_io_out,
  input wire logic [3:0] spi_io_oe,
  input wire logic write_enable_latch,
  input wire logic [2:0] security_lock_bits,
  input wire logic busy,
  input wire logic erase_start,
  input wire logic [1:0] erase_select,
  input wire logic latch_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Properties
  // ****
  int busy_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk) busy_cnt <= (rst || !busy) ? 0 : busy_cnt + 1;
  sequence s_launch; !busy ##1 busy; endsequence
  property p_wen; erase_start |-> write_enable_latch; endproperty
  property p_lock; erase_start |-> !security_lock_bits[erase_select]; endproperty
  property p_sel; erase_start |-> erase_select inside {2'h0, 2'h1, 2'h2}; endproperty
  property p_busy; erase_start |-> s_launch; endproperty
  property p_len; $fell(busy) |-> busy_cnt == ERASE_CYCLES; endproperty
  property p_clr; $fell(busy) |-> latch_clear; endproperty
  property p_clr_only; latch_clear |-> $past(busy) && !busy; endproperty
  property p_cs; erase_start |-> spi_cs_n && $past(spi_cs_n, 2); endproperty
  property p_idle; spi_cs_n[*6] |-> spi_io_oe == 4'h0; endproperty
  property p_hold; (!spi_cs_n && spi_sclk)[*4] |-> $stable(spi_io_out) && $stable(spi_io_oe); endproperty
  a_wen: assert property (p_wen) else $error("erase without write enable");
  a_lock: assert property (p_lock) else $error("erase of locked register");
  a_sel: assert property (p_sel) else $error("bad register select");
  a_busy: assert property (p_busy) else $error("busy not raised");
  a_len: assert property (p_len) else $error("erase length wrong");
  a_clr: assert property (p_clr) else $error("no latch clear at end");
  a_clr_only: assert property (p_clr_only) else $error("stray latch clear");
  a_cs: assert property (p_cs) else $error("erase before deselect");
  a_idle: assert property (p_idle) else $error("driving while deselected");
  a_hold: assert property (p_hold) else $error("output moved while clock high");
endmodule
bind fidsc_core fidsc_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) u_mon (.clk(clk), .rst(rst),
  .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe),
  .write_enable_latch(write_enable_latch), .security_lock_bits(security_lock_bits), .busy(busy),
  .erase_start(erase_start), .erase_select(erase_select), .latch_clear(latch_clear));
`default_nettype wire

// file: fidsc_host.sv
// Behavioural serial host that frames commands toward the device
`default_nettype none
module fidsc_host
  import fidsc_pkg::*;
(
  input wire logic clk,
  input wire logic [3:0] io_pin,
  output var fidsc_pins_type pins
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Bit timing
  // ****
  localparam int HALF = 5; // Phases above four clocks leave the pin sampler margin
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
  task automatic tick(input logic [3:0] v, input int lanes, inout logic [63:0] rd);
    pins.io <= v;
    repeat (HALF) @(posedge clk);
    pins.sclk <= 1'b1;
    case (lanes)
      4: rd = {rd[59:0], io_pin};
      2: rd = {rd[61:0], io_pin[1:0]};
      default: rd = {rd[62:0], io_pin[1]};
    endcase
    repeat (HALF) @(posedge clk);
    pins.sclk <= 1'b0;
  endtask
  task automatic frame(input logic [7:0] op, input int npre, input logic [31:0] pre, input int lanes,
    input int nbits, output logic [63:0] rd);
    rd = '0;
    @(posedge clk);
    pins.cs_n <= 1'b0;
    for (int i = 7; i >= 0; i--) tick({4{op[i]}}, 1, rd);
    for (int i = npre - 1; i >= 0; i--) tick({4{pre[i]}}, 1, rd);
    rd = '0;
    for (int i = 0; i < nbits; i += lanes) tick(~pins.io, lanes, rd);
    repeat (HALF) @(posedge clk);
    pins.cs_n <= 1'b1;
    pins.io <= ~pins.io;
    repeat (4 * HALF) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: fidsc_bench.sv
// Self-checking bench for identification reads and security erase
`default_nettype none
module fidsc_bench
  import fidsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Setup
  // ****
  localparam logic [7:0] MFR = 8'ha3; // Arbitrary value
  localparam logic [7:0] DEV = 8'h2e; // Arbitrary value
  localparam logic [7:0] TYP = 8'h61; // Arbitrary value
  localparam logic [7:0] CAP = 8'h19; // Arbitrary value
  localparam logic [63:0] UID = 64'h7e21_9c04_d3b8_56f1; // Arbitrary value
  localparam int ERASE = 20; // Short erase keeps the run brief
  logic clk, rst, we_latch, latch_clear, busy, erase_start;
  logic [2:0] lock;
  logic [1:0] esel, sel_seen;
  logic [3:0] io_out, io_oe, io_pin, oe_seen;
  logic [7:0] taddr;
  logic [7:0] tbl [256];
  logic [31:0] seed;
  fidsc_pins_type pins;
  int error_cnt, n_tests, starts, busy_len;
  assign io_pin = (io_oe & io_out) | (~io_oe & pins.io);
  fidsc_core #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP), .UNIQUE_ID(UID),
    .ERASE_CYCLES(ERASE)) uut (.clk(clk), .rst(rst), .spi_cs_n(pins.cs_n), .spi_sclk(pins.sclk),
    .spi_io_in(io_pin), .spi_io_out(io_out), .spi_io_oe(io_oe), .write_enable_latch(we_latch),
    .security_lock_bits(lock), .param_table_addr(taddr), .param_table_data(tbl[taddr]), .busy(busy),
    .erase_start(erase_start), .erase_select(esel), .latch_clear(latch_clear));
  fidsc_host host (.clk(clk), .io_pin(io_pin), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Status logic stand-in and erase observers
  always @(posedge clk) begin
    if (latch_clear === 1'b1) we_latch <= 1'b0;
    if (io_oe !== 4'h0) oe_seen <= io_oe;
    if (erase_start === 1'b1) starts <= starts + 1;
    if (erase_start === 1'b1) sel_seen <= esel;
    if (busy === 1'b1) busy_len <= busy_len + 1;
  end
  // ****
  // Model and checks
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] cyc(input logic [7:0] q[$], input int nbits);
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < nbits / 8; i++) v = {v[55:0], q[i % q.size()]};
    return v;
  endfunction
  task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_erase(input logic [31:0] got, input logic [31:0] exp);
    check_data({32'h0000_0000, got}, {32'h0000_0000, exp});
  endtask
  task automatic check_oe(input logic [3:0] got, input logic [3:0] exp);
    check_data({60'h0, got}, {60'h0, exp});
  endtask
  task automatic read_case(input logic [7:0] op, input int npre, input logic [31:0] pre, input int lanes,
    input int nbits, input logic [63:0] exp);
    logic [63:0] rd;
    oe_seen = 4'h0;
    host.frame(op, npre, pre, lanes, nbits, rd);
    check_data(rd, exp);
    check_oe(oe_seen, (lanes == 4) ? 4'hf : ((lanes == 2) ? 4'h3 : 4'h2));
    $display("read %h done", op);
  endtask
  task automatic erase_case(input logic w, input logic [2:0] lk, input logic [23:0] a, input int n,
    input logic ok);
    logic [63:0] rd;
    int s0, b0;
    @(posedge clk);
    we_latch <= w;
    lock <= lk;
    s0 = starts;
    b0 = busy_len;
    host.frame(OP_SEC_ERASE, n, {8'h00, a}, 1, 0, rd);
    repeat (ERASE + 10) @(posedge clk);
    check_erase(32'(starts - s0), {31'h0, ok});
    check_erase(32'(busy_len - b0), ok ? 32'(ERASE) : '0);
    check_erase({31'h0, we_latch}, {31'h0, w & !ok});
    if (ok) check_erase({30'h0, sel_seen}, {30'h0, a[13:12] - 2'h1});
    $display("erase %h done", a);
  endtask
  task automatic results;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    logic [7:0] a;
    logic [7:0] tq[$];
    rst = 1'b1;
    we_latch = 1'b0;
    lock = 3'h0;
    seed = 32'h0000_5fec;
    for (int i = 0; i < 256; i++) begin
      seed = lfsr(seed);
      tbl[i] = seed[7:0];
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int p = 0; p < 2; p++) begin
      read_case(OP_ID_SINGLE, 24, '0, 1, 32, cyc('{MFR, DEV}, 32));
      read_case(OP_ID_DUAL, 16, 32'h0000_000f, 2, 32, cyc('{MFR, DEV}, 32));
      read_case(OP_ID_QUAD, 12, 32'h0000_0003, 4, 32, cyc('{MFR, DEV}, 32));
      read_case(OP_UNIQUE_ID, 32, '0, 1, 64, UID);
      read_case(OP_STD_ID, 0, '0, 1, 48, cyc('{MFR, TYP, CAP}, 48));
      for (int k = 0; k < 2; k++) begin
        seed = lfsr(seed);
        a = k ? 8'hfc : seed[7:0];
        tq = {};
        for (int i = 0; i < 8; i++) tq.push_back(tbl[8'(a + i)]);
        read_case(OP_PARAM_TABLE, 32, {16'h0000, a, 8'h00}, 1, 64, cyc(tq, 64));
      end
      if (p == 0) begin
        erase_case(1'b0, 3'h0, 24'h00_1000, 24, 1'b0);
        erase_case(1'b1, 3'h6, 24'h00_10a5, 24, 1'b1);
        erase_case(1'b1, 3'h5, 24'h00_2000, 24, 1'b1);
        erase_case(1'b1, 3'h3, 24'h00_3000, 24, 1'b1);
        erase_case(1'b1, 3'h2, 24'h00_2000, 24, 1'b0);
        erase_case(1'b1, 3'h0, 24'h00_4000, 24, 1'b0);
        erase_case(1'b1, 3'h0, 24'h01_1000, 24, 1'b0);
        erase_case(1'b1, 3'h0, 24'h00_1100, 24, 1'b0);
        erase_case(1'b1, 3'h0, 24'h00_1000, 23, 1'b0);
        erase_case(1'b1, 3'h0, 24'h00_1000, 25, 1'b0);
      end
    end
    results();
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
